/* File: stholc_top.sv */
// Self-timing trigger, delayed value hold, direction sign and display multiplier
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module stholc_top
    import stholc_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic [stholc_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic [stholc_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic SAMPLE_VALID_IN,
    input wire logic signed [stholc_pkg::VAL_W-1:0] SAMPLE_IN,
    output logic [stholc_pkg::DATA_W-1:0] RDATA_OUT,
    output logic TIMING_OUT,
    output logic HOLD_STROBE_OUT,
    output logic HELD_VALID_OUT,
    output logic signed [stholc_pkg::VAL_W-1:0] HELD_OUT,
    output logic signed [stholc_pkg::DATA_W-1:0] DISP_OUT,
    output logic PENDING_OUT
);
    import stholc_pkg::*;

    generate
        if (CYCLES_PER_MS < 1)
        begin
            $error("stholc_top: CYCLES_PER_MS must be at least 1");
        end
    endgenerate

    localparam int DIV_W = $clog2(CYCLES_PER_MS + 1);
    localparam int PROD_W = VAL_W + MULT_W + 1;

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    logic [1:0] ttype_r;
    logic dmode_timer_r;
    logic stab_user_r;
    logic reverse_r;
    logic [1:0] calc_r;
    logic signed [VAL_W-1:0] level_r;
    logic signed [VAL_W-1:0] hyst_r;
    logic [MS_W-1:0] delay_r;
    logic signed [VAL_W-1:0] width_r;
    logic [MULT_W-1:0] mult_r;

    logic signed [VAL_W-1:0] wval;
    logic self_timing;
    logic dir_cfg_ok;

    function automatic logic in_range(input logic signed [VAL_W-1:0] v, input logic signed [VAL_W-1:0] lo);
        in_range = (v >= lo) && (v <= VAL_MAX);
    endfunction

    assign wval = WDATA_IN[VAL_W-1:0];
    assign self_timing = (ttype_r == TT_RISE) || (ttype_r == TT_FALL);
    assign dir_cfg_ok = (calc_r == CM_NOCALC) || (calc_r == CM_CALC);

    // Upper data bits must be a clean sign extension, else the write is dropped
    logic wval_ext_ok;
    assign wval_ext_ok = (WDATA_IN[DATA_W-1:VAL_W] == {(DATA_W-VAL_W){WDATA_IN[VAL_W-1]}});

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            ttype_r <= TT_EXTERNAL;
            dmode_timer_r <= 1'b0;
            stab_user_r <= 1'b0;
            calc_r <= CM_NOCALC;
        end
        else if (WR_IN && ADDR_IN == OFF_CTRL)
        begin
            ttype_r <= WDATA_IN[CTRL_TTYPE_LSB +: 2];
            dmode_timer_r <= WDATA_IN[CTRL_DMODE_BIT];
            stab_user_r <= WDATA_IN[CTRL_SUSER_BIT];
            calc_r <= WDATA_IN[CTRL_CALC_LSB +: 2];
        end
    end

    // Direction only follows when the calculation mode allows it
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            reverse_r <= 1'b0;
        else if (WR_IN && ADDR_IN == OFF_CTRL && dir_cfg_ok)
            reverse_r <= WDATA_IN[CTRL_REV_BIT];
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            level_r <= LEVEL_RST;
        else if (WR_IN && ADDR_IN == OFF_LEVEL && self_timing && wval_ext_ok && in_range(wval, VAL_MIN))
            level_r <= wval;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            hyst_r <= HYST_RST;
        else if (WR_IN && ADDR_IN == OFF_HYST && wval_ext_ok && in_range(wval, '0))
            hyst_r <= wval;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            delay_r <= DELAY_RST;
        else if (WR_IN && ADDR_IN == OFF_DELAY && dmode_timer_r && WDATA_IN <= DATA_W'(DELAY_MAX))
            delay_r <= WDATA_IN[MS_W-1:0];
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            width_r <= WIDTH_RST;
        else if (WR_IN && ADDR_IN == OFF_WIDTH && stab_user_r && wval_ext_ok && in_range(wval, '0))
            width_r <= wval;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            mult_r <= MULT_RST;
        else if (WR_IN && ADDR_IN == OFF_MULT && dir_cfg_ok
                 && WDATA_IN >= DATA_W'(MULT_MIN) && WDATA_IN <= DATA_W'(MULT_MAX))
            mult_r <= WDATA_IN[MULT_W-1:0];
    end

    // ---------------------------------------------------------------
    // Sample sign and self-timing comparison
    // ---------------------------------------------------------------
    logic signed [VAL_W-1:0] signed_val;
    logic signed [VAL_W-1:0] cur_r;
    logic signed [VAL_W:0] val_x;
    logic signed [VAL_W:0] hi_x;
    logic signed [VAL_W:0] lo_x;
    logic signed [VAL_W:0] lvl_x;
    logic armed_r;
    logic trig;

    // Negation stays in range: samples are limited to the symmetric span
    assign signed_val = reverse_r ? VAL_W'(-SAMPLE_IN) : SAMPLE_IN;
    assign val_x = {signed_val[VAL_W-1], signed_val};
    // Signed copy of the level; a bare concatenation would compare unsigned
    assign lvl_x = {level_r[VAL_W-1], level_r};
    assign hi_x = {level_r[VAL_W-1], level_r} + {hyst_r[VAL_W-1], hyst_r};
    assign lo_x = {level_r[VAL_W-1], level_r} - {hyst_r[VAL_W-1], hyst_r};

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            cur_r <= '0;
        else if (SAMPLE_VALID_IN)
            cur_r <= signed_val;
    end

    // Armed means the value sits on the far side of the band; crossing fires once
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN || !self_timing)
            armed_r <= 1'b0;
        else if (SAMPLE_VALID_IN)
        begin
            if (ttype_r == TT_RISE)
                armed_r <= (val_x > lvl_x) ? 1'b0 : (val_x < lo_x) ? 1'b1 : armed_r;
            else
                armed_r <= (val_x < lvl_x) ? 1'b0 : (val_x > hi_x) ? 1'b1 : armed_r;
        end
    end

    always_comb
    begin
        trig = 1'b0;
        if (SAMPLE_VALID_IN && self_timing && armed_r)
        begin
            if (ttype_r == TT_RISE)
                trig = val_x > lvl_x;
            else
                trig = val_x < lvl_x;
        end
    end

    // ---------------------------------------------------------------
    // Millisecond enable and hold evaluation
    // ---------------------------------------------------------------
    stholc_state_t state_r;
    logic [DIV_W-1:0] div_r;
    logic ms_tick;
    logic [MS_W-1:0] ms_left_r;
    logic stable;
    logic do_hold;
    logic start_eval;

    assign start_eval = trig && state_r == ST_IDLE;
    assign ms_tick = (div_r == DIV_W'(CYCLES_PER_MS - 1));

    // Divider restarts on the trigger so the first ms is a full one
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN || start_eval || ms_tick)
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            ms_left_r <= '0;
        else if (start_eval)
            ms_left_r <= delay_r;
        else if (state_r == ST_TIMER && ms_tick && ms_left_r != '0)
            ms_left_r <= ms_left_r - 1'b1;
    end

    stholc_stab #(
        .W(VAL_W)
    ) u_stab (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .start_in(start_eval),
        .active_in(state_r == ST_STAB),
        .sample_valid_in(SAMPLE_VALID_IN),
        .sample_in(signed_val),
        .width_in(stab_user_r ? width_r : WIDTH_FIXED),
        .stable_out(stable)
    );

    always_comb
    begin
        do_hold = 1'b0;
        unique case (state_r)
            ST_IDLE: do_hold = 1'b0;
            ST_TIMER: do_hold = (ms_left_r == '0);
            ST_STAB: do_hold = stable;
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            state_r <= ST_IDLE;
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (start_eval)
                        state_r <= dmode_timer_r ? ST_TIMER : ST_STAB;
                ST_TIMER, ST_STAB:
                    if (do_hold || !self_timing)
                        state_r <= ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Held value, display and status outputs
    // ---------------------------------------------------------------
    logic signed [PROD_W-1:0] prod;
    assign prod = $signed({HELD_OUT[VAL_W-1], HELD_OUT}) * $signed({1'b0, mult_r});

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            HELD_OUT <= '0;
            HELD_VALID_OUT <= 1'b0;
        end
        else if (do_hold)
        begin
            HELD_OUT <= cur_r;
            HELD_VALID_OUT <= 1'b1;
        end
    end

    // Display lags the held value by one cycle; truncation toward zero
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            DISP_OUT <= '0;
        else
            DISP_OUT <= DATA_W'(prod / $signed({1'b0, MULT_DEN}));
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
        begin
            TIMING_OUT <= 1'b0;
            HOLD_STROBE_OUT <= 1'b0;
            PENDING_OUT <= 1'b0;
        end
        else
        begin
            TIMING_OUT <= trig;
            HOLD_STROBE_OUT <= do_hold;
            PENDING_OUT <= (state_r != ST_IDLE && !do_hold && self_timing) || start_eval;
        end
    end

    // ---------------------------------------------------------------
    // Register read port
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (RESET_IN)
            RDATA_OUT <= '0;
        else if (RD_IN)
        begin
            unique case (ADDR_IN)
                OFF_CTRL: RDATA_OUT <= DATA_W'({calc_r, reverse_r, stab_user_r, dmode_timer_r, ttype_r});
                OFF_LEVEL: RDATA_OUT <= DATA_W'(level_r);
                OFF_HYST: RDATA_OUT <= DATA_W'(hyst_r);
                OFF_DELAY: RDATA_OUT <= DATA_W'(delay_r);
                OFF_WIDTH: RDATA_OUT <= DATA_W'(width_r);
                OFF_MULT: RDATA_OUT <= DATA_W'(mult_r);
                OFF_STATUS: RDATA_OUT <= DATA_W'({armed_r, HELD_VALID_OUT, state_r != ST_IDLE});
                OFF_HELD: RDATA_OUT <= DATA_W'(HELD_OUT);
                OFF_DISP: RDATA_OUT <= DISP_OUT;
                default: RDATA_OUT <= '0;
            endcase
        end
    end
endmodule

/* File: stholc_pkg.sv */
// Constants and types for the self-timing trigger and value-hold block
package stholc_pkg;
    // ---------------------------------------------------------------
    // Data format: signed values in units of 0.0001 mm
    // ---------------------------------------------------------------
    localparam int VAL_W = 22;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MULT_W = 11;
    localparam int MS_W = 14;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LEVEL = 8'h04;
    localparam logic [7:0] OFF_HYST = 8'h08;
    localparam logic [7:0] OFF_DELAY = 8'h0c;
    localparam logic [7:0] OFF_WIDTH = 8'h10;
    localparam logic [7:0] OFF_MULT = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_HELD = 8'h1c;
    localparam logic [7:0] OFF_DISP = 8'h20;

    // ---------------------------------------------------------------
    // Control and status field positions
    // ---------------------------------------------------------------
    localparam int CTRL_TTYPE_LSB = 0;
    localparam int CTRL_DMODE_BIT = 2;
    localparam int CTRL_SUSER_BIT = 3;
    localparam int CTRL_REV_BIT = 4;
    localparam int CTRL_CALC_LSB = 5;
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_HVALID_BIT = 1;
    localparam int STAT_ARMED_BIT = 2;

    // ---------------------------------------------------------------
    // Reset values and legal ranges
    // ---------------------------------------------------------------
    localparam logic signed [VAL_W-1:0] LEVEL_RST = 22'sh001388;
    localparam logic signed [VAL_W-1:0] VAL_MAX = 22'sh1e847f;
    localparam logic signed [VAL_W-1:0] VAL_MIN = -22'sh1e847f;
    localparam logic signed [VAL_W-1:0] HYST_RST = 22'sh00001e;
    localparam logic signed [VAL_W-1:0] WIDTH_RST = 22'sh000064;
    localparam logic signed [VAL_W-1:0] WIDTH_FIXED = 22'sh000064;
    localparam logic [MS_W-1:0] DELAY_RST = 14'h03e8;
    localparam logic [MS_W-1:0] DELAY_MAX = 14'h270f;
    localparam logic [MULT_W-1:0] MULT_RST = 11'h00a;
    localparam logic [MULT_W-1:0] MULT_MIN = 11'h001;
    localparam logic [MULT_W-1:0] MULT_MAX = 11'h3e8;
    localparam logic [MULT_W-1:0] MULT_DEN = 11'h00a;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int MS_PS = 1000000000;
    localparam int CYC_PER_MS = MS_PS / CLK_PERIOD_PS;

    // ---------------------------------------------------------------
    // Enumerations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {TT_EXTERNAL, TT_RISE, TT_FALL, TT_RSVD} stholc_ttype_t;
    typedef enum logic [1:0] {CM_NOCALC, CM_CALC, CM_OTHER, CM_RSVD} stholc_calc_t;
    typedef enum {ST_IDLE, ST_TIMER, ST_STAB} stholc_state_t;
endpackage

/* File: stholc_stab.sv */
// Stability checker: flags when successive samples differ by less than a width
`timescale 1ns/1ps
module stholc_stab
    import stholc_pkg::*;
#(
    parameter int W = VAL_W
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic active_in,
    input wire logic sample_valid_in,
    input wire logic signed [W-1:0] sample_in,
    input wire logic signed [W-1:0] width_in,
    output logic stable_out
);
    generate
        if (W < 4)
        begin
            $error("stholc_stab: width too small");
        end
    endgenerate

    logic signed [W-1:0] prev_r;
    logic have_prev_r;
    logic signed [W:0] diff;
    logic [W:0] spread;

    always_comb
    begin
        diff = {sample_in[W-1], sample_in} - {prev_r[W-1], prev_r};
        spread = diff[W] ? (W+1)'(-diff) : (W+1)'(diff);
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in || start_in || !active_in)
            have_prev_r <= 1'b0;
        else if (sample_valid_in)
            have_prev_r <= 1'b1;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            prev_r <= '0;
        else if (sample_valid_in)
            prev_r <= sample_in;
    end

    // Spread strictly below width; a zero width can never settle
    always_ff @(posedge clk_in)
    begin
        if (reset_in || start_in || !active_in)
            stable_out <= 1'b0;
        else
            stable_out <= sample_valid_in && have_prev_r
                && ($signed(spread) < $signed({width_in[W-1], width_in}));
    end
endmodule

/* File: stholc_sensor_model.sv */
// Sensor head model: one displacement sample every other clock
`timescale 1ns/1ps
module stholc_sensor_model
    import stholc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic signed [stholc_pkg::VAL_W-1:0] target_in,
    output logic valid_out,
    output logic signed [stholc_pkg::VAL_W-1:0] sample_out
);
    logic phase_r;
    logic signed [VAL_W-1:0] last_r;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            phase_r <= 1'b0;
            last_r <= '0;
        end
        else
        begin
            phase_r <= ~phase_r;
            if (!phase_r)
                last_r <= target_in;
        end
    end

    // Off-sample cycles carry garbage so a stale value is never mistaken for data
    assign valid_out = phase_r;
    assign sample_out = phase_r ? last_r : ~last_r;
endmodule

/* File: stholc_top_asserts.sv */
// Port-level checks on trigger, hold and read-back outputs
`timescale 1ns/1ps
module stholc_top_asserts
    import stholc_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic RD_IN,
    input wire logic SAMPLE_VALID_IN,
    input wire logic [stholc_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic TIMING_OUT,
    input wire logic HOLD_STROBE_OUT,
    input wire logic HELD_VALID_OUT,
    input wire logic signed [stholc_pkg::VAL_W-1:0] HELD_OUT,
    input wire logic PENDING_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_timing_single: assert property (TIMING_OUT |=> !TIMING_OUT)
        else $error("timing pulse longer than one cycle");
    a_timing_cause: assert property (TIMING_OUT |-> $past(SAMPLE_VALID_IN))
        else $error("timing pulse without a sample");
    a_trigger_pends: assert property (TIMING_OUT && !$past(PENDING_OUT) |-> PENDING_OUT)
        else $error("trigger did not start evaluation");
    a_pend_cause: assert property ($rose(PENDING_OUT) |-> TIMING_OUT)
        else $error("evaluation started without trigger");
    a_strobe_ends: assert property (HOLD_STROBE_OUT |-> HELD_VALID_OUT && !PENDING_OUT)
        else $error("hold strobe with bad status");
    a_strobe_single: assert property (HOLD_STROBE_OUT |=> !HOLD_STROBE_OUT)
        else $error("hold strobe longer than one cycle");
    a_held_kept: assert property (!HOLD_STROBE_OUT |-> $stable(HELD_OUT))
        else $error("held value changed without strobe");
    a_valid_sticky: assert property (HELD_VALID_OUT |=> HELD_VALID_OUT)
        else $error("held valid dropped");
    a_rdata_kept: assert property (!$past(RD_IN) |-> $stable(RDATA_OUT))
        else $error("read data changed without read");

    c_hold: cover property (HOLD_STROBE_OUT);
    c_ignored: cover property (TIMING_OUT && $past(PENDING_OUT));
    c_long_pend: cover property (PENDING_OUT [*8]);
endmodule

bind stholc_top stholc_top_asserts #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_asserts (.CLK_IN(CLK_IN),
    .RESET_IN(RESET_IN), .RD_IN(RD_IN), .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .RDATA_OUT(RDATA_OUT),
    .TIMING_OUT(TIMING_OUT), .HOLD_STROBE_OUT(HOLD_STROBE_OUT), .HELD_VALID_OUT(HELD_VALID_OUT),
    .HELD_OUT(HELD_OUT), .PENDING_OUT(PENDING_OUT));

/* File: testbench.sv */
// Self-checking bench for the self-timing trigger and hold block
`timescale 1ns/1ps
module testbench;
    import stholc_pkg::*;
    // Short millisecond keeps timer runs brief
    localparam int CPM = 4;
    logic clk = 0;
    logic rst = 1;
    logic wr = 0;
    logic rd = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    logic sv, tim, hs, hv, pend;
    logic pend_d = 0;
    logic signed [VAL_W-1:0] smpl, held;
    logic signed [VAL_W-1:0] tgt = '0;
    logic signed [DATA_W-1:0] disp;
    int err_count = 0;
    int check_count = 0;
    int seed = 32'hdca7;
    int cyc = 0, t_trig = 0, t_hold = 0, n_trig = 0, n_hold = 0;
    logic [7:0] rst_a[6] = '{OFF_CTRL, OFF_LEVEL, OFF_HYST, OFF_DELAY, OFF_WIDTH, OFF_MULT};
    int rst_v[6] = '{0, 5000, 30, 1000, 100, 10};
    int dly[2] = '{0, 2};

    initial forever #4 clk = ~clk;

    stholc_sensor_model head (.clk_in(clk), .reset_in(rst), .target_in(tgt), .valid_out(sv), .sample_out(smpl));
    stholc_top #(.CYCLES_PER_MS(CPM)) uut (.CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .SAMPLE_VALID_IN(sv), .SAMPLE_IN(smpl), .RDATA_OUT(rdata), .TIMING_OUT(tim),
        .HOLD_STROBE_OUT(hs), .HELD_VALID_OUT(hv), .HELD_OUT(held), .DISP_OUT(disp), .PENDING_OUT(pend));

    // ---------------------------------------------------------------
    // Event bookkeeping; only a trigger seen while idle starts the clock
    // ---------------------------------------------------------------
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        pend_d <= pend;
        if (tim === 1'b1)
            n_trig <= n_trig + 1;
        if (tim === 1'b1 && pend_d === 1'b0)
            t_trig <= cyc;
        if (hs === 1'b1)
            t_hold <= cyc;
        if (hs === 1'b1)
            n_hold <= n_hold + 1;
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input int d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input int e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    // Exactly one head sample of value v per call
    task automatic smp(input int v);
        tgt <= v;
        repeat (2) @(posedge clk);
    endtask

    task automatic hold_chk(input int e, input int m);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end
        while (hs !== 1'b1 && n < 200);
        chk(hs, 1'b1);
        chk(held, e);
        chk(hv, 1'b1);
        @(posedge clk);
        #1 chk(disp, (e * m) / 10);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Whole run needs a few hundred cycles; give ample margin
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize;
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        int lv, a, b, m;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Park the head at the bottom so level writes never cause a stray crossing
        tgt <= VAL_MIN;
        foreach (rst_a[i])
            rd_chk(rst_a[i], rst_v[i]);
        rd_chk(8'h24, 0);
        wr_reg(OFF_LEVEL, 6000);
        rd_chk(OFF_LEVEL, 5000);
        wr_reg(OFF_DELAY, 0);
        rd_chk(OFF_DELAY, 1000);
        wr_reg(OFF_WIDTH, 50);
        rd_chk(OFF_WIDTH, 100);
        wr_reg(OFF_CTRL, 5);
        wr_reg(OFF_LEVEL, 2000000);
        rd_chk(OFF_LEVEL, 5000);
        wr_reg(OFF_LEVEL, -1999999);
        rd_chk(OFF_LEVEL, -1999999);
        wr_reg(OFF_DELAY, 10000);
        wr_reg(OFF_DELAY, 9999);
        rd_chk(OFF_DELAY, 9999);
        wr_reg(OFF_LEVEL, 6000);
        done("registers");
        foreach (dly[i])
        begin
            wr_reg(OFF_DELAY, dly[i]);
            smp(5000);
            smp(6100);
            hold_chk(6100, 10);
            chk(t_hold - t_trig inside {[dly[i] * CPM : dly[i] * CPM + 2]}, 1'b1);
        end
        wr_reg(OFF_DELAY, 3);
        a = n_hold;
        b = n_trig;
        smp(5000);
        smp(6100);
        smp(5000);
        smp(6200);
        #1 chk(pend, 1'b1);
        hold_chk(6200, 10);
        chk(t_hold - t_trig inside {[3 * CPM : 3 * CPM + 2]}, 1'b1);
        chk(n_hold - a, 1);
        chk(n_trig - b, 2);
        done("timer");
        wr_reg(OFF_DELAY, 0);
        a = n_trig;
        smp(5980);
        smp(6100);
        repeat (4) @(posedge clk);
        chk(n_trig - a, 0);
        smp(5969);
        smp(6001);
        hold_chk(6001, 10);
        wr_reg(OFF_HYST, 0);
        smp(5999);
        smp(6001);
        hold_chk(6001, 10);
        wr_reg(OFF_HYST, 30);
        wr_reg(OFF_CTRL, 6);
        smp(6031);
        smp(5999);
        hold_chk(5999, 10);
        done("hysteresis");
        wr_reg(OFF_CTRL, 'h15);
        wr_reg(OFF_LEVEL, 6000);
        wr_reg(OFF_MULT, 25);
        wr_reg(OFF_MULT, 0);
        wr_reg(OFF_MULT, 1001);
        rd_chk(OFF_MULT, 25);
        smp(-5000);
        smp(-6100);
        hold_chk(6100, 25);
        wr_reg(OFF_CTRL, 'h45);
        wr_reg(OFF_CTRL, 'h55);
        rd_chk(OFF_CTRL, 'h45);
        wr_reg(OFF_MULT, 30);
        rd_chk(OFF_MULT, 25);
        done("direction");
        wr_reg(OFF_CTRL, 1);
        smp(5000);
        smp(6100);
        smp(6300);
        smp(6500);
        smp(6599);
        hold_chk(6599, 25);
        wr_reg(OFF_CTRL, 9);
        wr_reg(OFF_WIDTH, 50);
        rd_chk(OFF_WIDTH, 50);
        smp(5000);
        smp(6100);
        smp(6160);
        smp(6200);
        hold_chk(6200, 25);
        done("static");
        wr_reg(OFF_CTRL, 5);
        repeat (8)
        begin
            lv = $random(seed) % 100000;
            m = 1 + ($unsigned($random(seed)) % 1000);
            a = lv - 31 - ($random(seed) & 255);
            b = lv + 1 + ($random(seed) & 255);
            wr_reg(OFF_LEVEL, lv);
            wr_reg(OFF_MULT, m);
            smp(a);
            smp(b);
            hold_chk(b, m);
        end
        done("random");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk(hv, 1'b0);
        chk(held, 0);
        rd_chk(OFF_LEVEL, 5000);
        done("reset");
        summarize;
    end
endmodule
